// [hdl/abc_pkg.sv]
// Shared constants, types and decode helper for the AND, branch and bit-clear group.
`default_nettype none

package abc_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned PC_W   = 21;
  localparam int unsigned ADDR_W = 12;
  localparam int unsigned BANK_W = 4;

  // ----------------------------------------------------------------
  // Opcode encodings and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] OPC_AND_IMM   = 8'h0b;
  localparam logic [5:0] OPC_AND_FILE  = 6'h05;
  localparam logic [7:0] OPC_BR_CARRY  = 8'he2;
  localparam logic [3:0] OPC_CLR_BIT   = 4'h9;
  localparam int unsigned DEST_BIT     = 9;
  localparam int unsigned ACCESS_BIT   = 8;
  localparam int unsigned BIT_IDX_LSB  = 9;

  // ----------------------------------------------------------------
  // Addressing constants
  // ----------------------------------------------------------------
  localparam logic [7:0]        INDEX_MAX    = 8'h5f;
  localparam logic [7:0]        ACC_SPLIT    = 8'h80;
  localparam logic [BANK_W-1:0] ACC_LO_BANK  = 4'h0;
  localparam logic [BANK_W-1:0] ACC_HI_BANK  = 4'hf;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [7:0]      ACC_RST  = 8'h00;
  localparam logic [15:0]     INSTR_RST = 16'h0000;
  localparam logic [PC_W-1:0] PC_RST   = 21'h000000;

  // Instruction clock phases and decoded operations.
  typedef enum logic [1:0] {PH_Q1, PH_Q2, PH_Q3, PH_Q4} abc_phase_t;
  typedef enum logic [2:0] {OP_NONE, OP_AND_IMM, OP_AND_FILE,
                            OP_BR_CARRY, OP_CLR_BIT} abc_op_t;

  // Maps an instruction word onto the operation of this group.
  function automatic abc_op_t abc_decode(input logic [15:0] w);
    abc_op_t op;
    op = OP_NONE;
    if (w[15:8] == OPC_AND_IMM) op = OP_AND_IMM;
    else if (w[15:10] == OPC_AND_FILE) op = OP_AND_FILE;
    else if (w[15:8] == OPC_BR_CARRY) op = OP_BR_CARRY;
    else if (w[15:12] == OPC_CLR_BIT) op = OP_CLR_BIT;
    return op;
  endfunction : abc_decode

endpackage : abc_pkg

`default_nettype wire

// [hdl/abc_addr_if.sv]
// Interface carrying the register address fields to the address selector.
`timescale 1ns/1ps
`default_nettype none

interface abc_addr_if;
  import abc_pkg::*;
  logic [7:0]        file_sel;
  logic              access_sel;
  logic              ext_en;
  logic [BANK_W-1:0] bank;
  logic [ADDR_W-1:0] index_base;
  logic [ADDR_W-1:0] addr;
  logic              indexed;

  modport core (output file_sel, access_sel, ext_en, bank, index_base,
                input  addr, indexed);
  modport sel  (input  file_sel, access_sel, ext_en, bank, index_base,
                output addr, indexed);
endinterface : abc_addr_if

`default_nettype wire

// [hdl/abc_phase_gen.sv]
// Four-phase instruction clock sequencer.
`timescale 1ns/1ps
`default_nettype none

module abc_phase_gen (
  input  wire logic            clk_in,
  input  wire logic            rstn_in,
  output var  abc_pkg::abc_phase_t phase_out
);
  import abc_pkg::*;

  abc_phase_t phase_d;

  // Phases step Q1 to Q4 and wrap.
  assign phase_d = (phase_out == PH_Q4) ? PH_Q1 : abc_phase_t'(phase_out + 2'h1);

  // Phase register starts in Q1.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      phase_out <= PH_Q1;
    end else begin
      phase_out <= phase_d;
    end
  end
endmodule : abc_phase_gen

`default_nettype wire

// [hdl/abc_addr_sel.sv]
// Data-memory address selection: access bank, bank pointer or indexed offset.
`timescale 1ns/1ps
`default_nettype none

module abc_addr_sel (
  abc_addr_if.sel a
);
  import abc_pkg::*;

  logic [ADDR_W-1:0] acc_addr;
  logic [ADDR_W-1:0] bank_addr;
  logic [ADDR_W-1:0] idx_addr;

  // Indexed mode needs the extended set, access bit clear and a low field.
  assign a.indexed  = a.ext_en && !a.access_sel && (a.file_sel <= INDEX_MAX);
  // Access bank covers the low part of bank 0 and the top of the last bank.
  assign acc_addr   = {(a.file_sel < ACC_SPLIT) ? ACC_LO_BANK : ACC_HI_BANK, a.file_sel};
  assign bank_addr  = {a.bank, a.file_sel};
  assign idx_addr   = a.index_base + {4'h0, a.file_sel};
  // Final address selection.
  assign a.addr     = a.indexed ? idx_addr : (a.access_sel ? bank_addr : acc_addr);
endmodule : abc_addr_sel

`default_nettype wire

// [hdl/abc_exec.sv]
// Decode and execute core for the AND, branch-if-carry and bit-clear group.
//
// Functional notes
// - The AND-immediate opcode ANDs the accumulator with the literal into the accumulator.
// - The AND-register opcode ANDs the accumulator with the addressed register.
// - Destination bit 0 sends the AND-register result to the accumulator, 1 to the register.
// - AND-register sets only sign and zero flags from the result, not carry or overflow.
// - Access bit 0 selects the access bank, access bit 1 takes the bank pointer.
// - With the extended set on, access bit 0 and field up to 95, indexed offset is used.
// - Branch-on-carry jumps only when carry is 1, else the next instruction follows.
// - A taken branch loads the incremented counter plus twice the signed offset.
// - The branch takes one cycle untaken and two taken, the second being a no-operation.
// - Branch-on-carry changes no status flag whether taken or not.
// - Bit clear zeroes only the chosen bit of the register and changes no flag.
`timescale 1ns/1ps
`default_nettype none

module abc_exec (
  input  wire logic                       clk_in,
  input  wire logic                       rstn_in,
  input  wire logic                       instr_valid_in,
  input  wire logic [15:0]                instr_in,
  input  wire logic                       ext_set_en_in,
  input  wire logic                       acc_load_in,
  input  wire logic [7:0]                 acc_load_data_in,
  input  wire logic [abc_pkg::BANK_W-1:0] bank_pointer_in,
  input  wire logic [abc_pkg::ADDR_W-1:0] index_base_in,
  input  wire logic                       carry_in,
  input  wire logic [abc_pkg::PC_W-1:0]   pc_in,
  input  wire logic [7:0]                 file_rdata_in,
  output logic      [1:0]                 phase_out,
  output logic      [7:0]                 acc_out,
  output logic      [abc_pkg::ADDR_W-1:0] file_addr_out,
  output logic                            file_rd_out,
  output logic                            file_wr_out,
  output logic      [7:0]                 file_wdata_out,
  output logic                            flag_we_out,
  output logic                            neg_out,
  output logic                            zero_out,
  output logic                            pc_load_out,
  output logic      [abc_pkg::PC_W-1:0]   pc_value_out,
  output logic                            busy_out
);
  import abc_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  abc_phase_t        phase_q;
  abc_op_t           op_q;
  abc_op_t           op_d;
  logic [15:0]       instr_q;
  logic [7:0]        acc_q;
  logic [7:0]        result_q;
  logic [7:0]        result_d;
  logic [ADDR_W-1:0] file_addr_q;
  logic              file_rd_q;
  logic              file_wr_q;
  logic [7:0]        file_wdata_q;
  logic              flag_we_q;
  logic              neg_q;
  logic              zero_q;
  logic              pc_load_q;
  logic [PC_W-1:0]   pc_value_q;
  logic              nop_q;

  // ----------------------------------------------------------------
  // Submodules
  // ----------------------------------------------------------------
  abc_addr_if addr_bus ();

  abc_phase_gen u_phase (
    .clk_in    (clk_in),
    .rstn_in   (rstn_in),
    .phase_out (phase_q)
  );

  abc_addr_sel u_addr (
    .a (addr_bus.sel)
  );

  // File select and access bit come from the latched instruction word; mode, bank and index base come from the inputs.
  assign addr_bus.file_sel   = instr_q[7:0];
  assign addr_bus.access_sel = instr_q[ACCESS_BIT];
  assign addr_bus.ext_en     = ext_set_en_in;
  assign addr_bus.bank       = bank_pointer_in;
  assign addr_bus.index_base = index_base_in;

  // ----------------------------------------------------------------
  // Decode and datapath
  // ----------------------------------------------------------------
  logic              uses_file;
  logic              dest_file;
  logic [2:0]        bit_idx;
  logic [7:0]        clr_mask;
  logic [7:0]        branch_off;
  logic [PC_W-1:0]   branch_tgt;
  logic              take_branch;
  logic              is_q1;
  logic              is_q2;
  logic              is_q3;
  logic              is_q4;

  // Phase strobes.
  assign is_q1 = (phase_q == PH_Q1);
  assign is_q2 = (phase_q == PH_Q2);
  assign is_q3 = (phase_q == PH_Q3);
  assign is_q4 = (phase_q == PH_Q4);

  // A fetched word is ignored during the no-operation cycle of a branch.
  assign op_d = (instr_valid_in && !nop_q) ? abc_decode(instr_in) : OP_NONE;

  // Register-addressed operations read the data memory.
  assign uses_file = (op_q == OP_AND_FILE) || (op_q == OP_CLR_BIT);
  assign dest_file = instr_q[DEST_BIT];
  assign bit_idx   = instr_q[BIT_IDX_LSB +: 3];
  assign clr_mask  = ~(8'h01 << bit_idx);

  // Branch target uses the incremented counter plus twice the offset.
  assign branch_off  = instr_q[7:0];
  assign branch_tgt  = pc_in + {{(PC_W-9){branch_off[7]}}, branch_off, 1'b0};
  assign take_branch = (op_q == OP_BR_CARRY) && carry_in;

  // Result selection per operation.
  always_comb begin
    result_d = result_q;
    unique case (op_q)
      OP_AND_IMM:  result_d = acc_q & instr_q[7:0];
      OP_AND_FILE: result_d = acc_q & file_rdata_in;
      OP_CLR_BIT:  result_d = file_rdata_in & clr_mask;
      OP_BR_CARRY: result_d = result_q;
      OP_NONE:     result_d = result_q;
    endcase
  end

  // ----------------------------------------------------------------
  // Q1 decode and Q2 read
  // ----------------------------------------------------------------
  // Q1 latches the word; Q2 issues the register read.
  // decode then read
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      op_q        <= OP_NONE;
      instr_q     <= INSTR_RST;
      file_addr_q <= '0;
      file_rd_q   <= 1'b0;
    end else begin
      file_rd_q <= 1'b0;
      if (is_q1) begin
        op_q    <= op_d;
        instr_q <= instr_in;
      end
      if (is_q2 && uses_file) begin
        file_addr_q <= addr_bus.addr;
        file_rd_q   <= 1'b1;
      end
    end
  end

  // ----------------------------------------------------------------
  // Q3 compute
  // ----------------------------------------------------------------
  // latch the operation result
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      result_q <= ACC_RST;
    end else if (is_q3) begin
      result_q <= result_d;
    end
  end

  // ----------------------------------------------------------------
  // Q4 write back
  // ----------------------------------------------------------------
  // Destination, flag and counter writes all happen at the Q4 edge.
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      acc_q        <= ACC_RST;
      file_wr_q    <= 1'b0;
      file_wdata_q <= 8'h00;
      flag_we_q    <= 1'b0;
      neg_q        <= 1'b0;
      zero_q       <= 1'b0;
      pc_load_q    <= 1'b0;
      pc_value_q   <= PC_RST;
      nop_q        <= 1'b0;
    end else begin
      file_wr_q <= 1'b0;
      flag_we_q <= 1'b0;
      pc_load_q <= 1'b0;
      // The core may load the accumulator outside Q4; the Q4 write slot owns it.
      if (acc_load_in && !is_q4) begin
        acc_q <= acc_load_data_in;
      end
      if (is_q4) begin
        nop_q <= take_branch;
        if (op_q == OP_AND_IMM) begin
          acc_q <= result_q;
        end
        if (op_q == OP_AND_FILE && !dest_file) begin
          acc_q <= result_q;
        end
        if ((op_q == OP_AND_FILE && dest_file) || op_q == OP_CLR_BIT) begin
          file_wr_q    <= 1'b1;
          file_wdata_q <= result_q;
        end
        if (op_q == OP_AND_IMM || op_q == OP_AND_FILE) begin
          flag_we_q <= 1'b1;
          neg_q     <= result_q[7];
          zero_q    <= (result_q == 8'h00);
        end
        if (take_branch) begin
          pc_load_q  <= 1'b1;
          pc_value_q <= branch_tgt;
        end
      end
    end
  end

  // Outputs come straight from the registers above.
  assign phase_out      = phase_q;
  assign acc_out        = acc_q;
  assign file_addr_out  = file_addr_q;
  assign file_rd_out    = file_rd_q;
  assign file_wr_out    = file_wr_q;
  assign file_wdata_out = file_wdata_q;
  assign flag_we_out    = flag_we_q;
  assign neg_out        = neg_q;
  assign zero_out       = zero_q;
  assign pc_load_out    = pc_load_q;
  assign pc_value_out   = pc_value_q;
  assign busy_out       = nop_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // literal into acc
  and_imm_result_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (is_q3 && op_q == OP_AND_IMM) |=> ##1 acc_q == ($past(acc_q, 2) & $past(instr_q[7:0], 2)))
    else $error("AND literal result wrong");

  and_file_result_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (is_q3 && op_q == OP_AND_FILE) |=> result_q == ($past(acc_q) & $past(file_rdata_in)))
    else $error("AND register result wrong");

  dest_select_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (is_q4 && op_q == OP_AND_FILE) |=>
      (file_wr_q == $past(dest_file)) &&
      (acc_q == ($past(dest_file) ? $past(acc_q) : $past(result_q))))
    else $error("AND register destination wrong");

  and_flags_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (is_q4 && op_q == OP_AND_FILE) |=>
      flag_we_q && neg_q == $past(result_q[7]) && zero_q == ($past(result_q) == 8'h00))
    else $error("AND register flags wrong");

  bank_select_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (is_q2 && uses_file && instr_q[ACCESS_BIT]) |=>
      file_rd_q && file_addr_q == {$past(bank_pointer_in), $past(instr_q[7:0])})
    else $error("Bank pointer address wrong");

  indexed_addr_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (is_q2 && uses_file && ext_set_en_in && !instr_q[ACCESS_BIT] &&
     instr_q[7:0] <= INDEX_MAX) |=>
      file_addr_q == $past(index_base_in + {4'h0, instr_q[7:0]}))
    else $error("Indexed address wrong");

  branch_taken_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (is_q4 && op_q == OP_BR_CARRY) |=>
      pc_load_q == $past(carry_in) &&
      (!pc_load_q || pc_value_q == $past(branch_tgt)))
    else $error("Branch on carry wrong");

  branch_nop_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    pc_load_q |-> busy_out ##1 (op_q == OP_NONE)[*4] ##1 !busy_out)
    else $error("Branch no-operation cycle wrong");

  branch_flags_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (is_q4 && (op_q == OP_BR_CARRY || op_q == OP_CLR_BIT)) |=>
      !flag_we_q && $stable(neg_q) && $stable(zero_q))
    else $error("Flags changed by branch or bit clear");

  clear_bit_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    (is_q3 && op_q == OP_CLR_BIT) |=> ##1
      file_wr_q && file_wdata_q == ($past(file_rdata_in, 2) & ~(8'h01 << $past(bit_idx, 2))))
    else $error("Bit clear result wrong");

  phase_order_a: assert property (@(posedge clk_in) disable iff (!rstn_in)
    file_rd_q |-> is_q3 ##1 is_q4 ##1 (is_q1 && file_wr_q == $past(uses_file && op_q != OP_AND_FILE
      || (op_q == OP_AND_FILE && dest_file))))
    else $error("Phase ordering wrong");

endmodule : abc_exec

`default_nettype wire

// [bench/abc_file_model.sv]
// Behavioural data-memory file that answers the block's read and write strobes.
`timescale 1ns/1ps
`default_nettype none

module abc_file_model (
  input  wire logic                       clk_in,
  input  wire logic [abc_pkg::ADDR_W-1:0] file_addr_in,
  input  wire logic                       file_rd_in,
  input  wire logic                       file_wr_in,
  input  wire logic [7:0]                 file_wdata_in,
  output logic      [7:0]                 file_rdata_out
);
  import abc_pkg::*;

  logic [7:0] mem [4096];
  logic [7:0] last_q;

  // Fills every location with a value that differs from its neighbours, except 0x7ff and 0x800, which hold the same value.
  initial begin
    for (int i = 0; i < 4096; i++) begin
      mem[i] = 8'(i) ^ {4'(i >> 8), 4'(i >> 8)} ^ 8'ha5;
    end
    last_q = 8'h00;
  end

  // Flow-through read; outside a read the bus shows the inverse of its last value.
  assign file_rdata_out = file_rd_in ? mem[file_addr_in] : ~last_q;

  // Stores writes and remembers the last value read.
  always @(posedge clk_in) begin
    if (file_wr_in) begin
      mem[file_addr_in] <= file_wdata_in;
    end
    if (file_rd_in) begin
      last_q <= mem[file_addr_in];
    end
  end
endmodule : abc_file_model

`default_nettype wire

// [bench/and_branch_bitclear_exec_bench.sv]
// Self-checking testbench for the AND, branch-if-carry and bit-clear execute core.
`timescale 1ns/1ps
`default_nettype none

module and_branch_bitclear_exec_bench;
  import abc_pkg::*;

  logic               clk_in, rstn_in, instr_valid_in, ext_set_en_in, carry_in;
  logic [15:0]        instr_in;
  logic [BANK_W-1:0]  bank_pointer_in;
  logic [ADDR_W-1:0]  index_base_in, file_addr_out, ea;
  logic [PC_W-1:0]    pc_in, pc_value_out;
  logic [7:0]         file_rdata_in, acc_out, file_wdata_out, f, old, old2, n;
  logic [7:0]         acc_exp, acc_load_data_in;
  logic [1:0]         phase_out, flg;
  logic               file_rd_out, file_wr_out, flag_we_out, neg_out, zero_out;
  logic               pc_load_out, busy_out, e, a, acc_load_in;
  logic               nx_ext, nx_carry;
  logic [BANK_W-1:0]  nx_bp, bp;
  logic [PC_W-1:0]    nx_pc;
  int                 mismatches, check_count, cycles;
  logic [25:0]        tab [8];
  logic [7:0]         offs [3];

  abc_exec dut (
    .clk_in(clk_in), .rstn_in(rstn_in), .instr_valid_in(instr_valid_in),
    .instr_in(instr_in), .ext_set_en_in(ext_set_en_in), .bank_pointer_in(bank_pointer_in),
    .index_base_in(index_base_in), .carry_in(carry_in), .pc_in(pc_in),
    .file_rdata_in(file_rdata_in), .phase_out(phase_out), .acc_out(acc_out),
    .file_addr_out(file_addr_out), .file_rd_out(file_rd_out), .file_wr_out(file_wr_out),
    .file_wdata_out(file_wdata_out), .flag_we_out(flag_we_out), .neg_out(neg_out),
    .zero_out(zero_out), .pc_load_out(pc_load_out), .pc_value_out(pc_value_out),
    .busy_out(busy_out), .acc_load_in(acc_load_in), .acc_load_data_in(acc_load_data_in)
  );

  abc_file_model u_mem (
    .clk_in(clk_in), .file_addr_in(file_addr_out), .file_rd_in(file_rd_out),
    .file_wr_in(file_wr_out), .file_wdata_in(file_wdata_out), .file_rdata_out(file_rdata_in)
  );

  // Makes the 250 MHz clock.
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end

  // Compares one value and counts the comparison.
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  // Issues one word so the next Q1 edge takes it, then stops just after its Q4 edge.
  task automatic run(input logic [15:0] w, input logic [15:0] nxt, input logic nv);
    @(negedge clk_in);
    while (phase_out !== 2'd3) @(negedge clk_in);
    @(posedge clk_in);
    instr_in        <= w;
    instr_valid_in  <= 1'b1;
    ext_set_en_in   <= nx_ext;
    bank_pointer_in <= nx_bp;
    carry_in        <= nx_carry;
    pc_in           <= nx_pc;
    @(posedge clk_in);
    instr_in       <= nxt;
    instr_valid_in <= nv;
    repeat (3) @(posedge clk_in);
    #1;
  endtask : run

  // Loads the accumulator at a Q2 edge, away from the Q4 write slot.
  task automatic load(input logic [7:0] v);
    @(negedge clk_in);
    while (phase_out !== 2'd0) @(negedge clk_in);
    @(posedge clk_in);
    acc_load_in      <= 1'b1;
    acc_load_data_in <= v;
    @(posedge clk_in);
    acc_load_in <= 1'b0;
    #1;
  endtask : load

  // Checks the result outputs seen in the cycle after the Q4 edge.
  task automatic outs(input logic [7:0] acc, input logic wr, input logic fwe,
                      input logic pl, input logic bsy);
    chk(acc_out, acc);
    chk({file_wr_out, flag_we_out, pc_load_out, busy_out}, {wr, fwe, pl, bsy});
  endtask : outs

  // Prints the counts and the verdict, then ends the run.
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : conclude

  // Cuts a hang short.
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      mismatches++;
      conclude();
    end
  end

  // Main test sequence.
  initial begin
    rstn_in = 1'b0; instr_valid_in = 1'b0; instr_in = 16'h0000; ext_set_en_in = 1'b0;
    bank_pointer_in = 4'h0; index_base_in = 12'h300; carry_in = 1'b0; pc_in = 21'h000000;
    nx_ext = 1'b0; nx_bp = 4'h0; nx_carry = 1'b0; nx_pc = 21'h001000;
    acc_load_in = 1'b0; acc_load_data_in = 8'h00;
    offs = '{8'h80, 8'h7f, 8'h05};
    tab = '{{1'b1, 1'b0, 4'h0, 8'h5f, 12'h35f}, {1'b1, 1'b0, 4'h0, 8'h60, 12'h060},
            {1'b1, 1'b1, 4'h5, 8'h20, 12'h520}, {1'b0, 1'b0, 4'h0, 8'h10, 12'h010},
            {1'b0, 1'b0, 4'h0, 8'h90, 12'hf90}, {1'b1, 1'b0, 4'h0, 8'h00, 12'h300},
            {1'b0, 1'b1, 4'ha, 8'hff, 12'haff}, {1'b1, 1'b0, 4'h0, 8'h80, 12'hf80}};
    repeat (16) @(posedge clk_in);
    rstn_in <= 1'b1;
    #1;
    chk({phase_out, acc_out, neg_out, zero_out, busy_out, pc_load_out, file_wr_out}, 32'h0);
    $display("test reset finished");
    load(8'ha3);
    chk(acc_out, 8'ha3);
    acc_exp = 8'ha3;
    foreach (offs[i]) begin
      acc_exp = acc_exp & offs[i];
      run({OPC_AND_IMM, offs[i]}, 16'h0000, 1'b0);
      outs(acc_exp, 1'b0, 1'b1, 1'b0, 1'b0);
      chk({neg_out, zero_out}, {acc_exp[7], acc_exp == 8'h00});
    end
    $display("test and literal finished");
    for (int i = 0; i < 8; i++) begin
      {e, a, bp, f, ea} = tab[i];
      nx_ext = e;
      nx_bp  = bp;
      old    = u_mem.mem[ea];
      run({OPC_CLR_BIT, 3'(i), a, f}, 16'h0000, 1'b0);
      chk(file_addr_out, ea);
      outs(8'h00, 1'b1, 1'b0, 1'b0, 1'b0);
      chk({neg_out, zero_out, file_wdata_out}, {2'b01, old & ~(8'h01 << i)});
      @(posedge clk_in);
      #1;
      chk(u_mem.mem[ea], old & ~(8'h01 << i));
    end
    $display("test bit clear finished");
    nx_ext = 1'b0;
    nx_bp  = 4'h2;
    old    = u_mem.mem[12'h233];
    load(8'h5c);
    acc_exp = 8'h5c & old;
    run({OPC_AND_FILE, 1'b0, 1'b1, 8'h33}, 16'h0000, 1'b0);
    chk(file_addr_out, 12'h233);
    outs(acc_exp, 1'b0, 1'b1, 1'b0, 1'b0);
    chk({neg_out, zero_out}, {acc_exp[7], acc_exp == 8'h00});
    run({OPC_AND_FILE, 1'b1, 1'b1, 8'h33}, 16'h0000, 1'b0);
    chk(u_mem.mem[12'h233], old);
    outs(acc_exp, 1'b1, 1'b1, 1'b0, 1'b0);
    n   = acc_exp & old;
    flg = {n[7], n == 8'h00};
    chk({neg_out, zero_out, file_wdata_out}, {flg, n});
    @(posedge clk_in);
    #1;
    chk(u_mem.mem[12'h233], n);
    $display("test and register finished");
    nx_bp = 4'h7;
    run({OPC_BR_CARRY, 8'h05}, 16'h0000, 1'b0);
    outs(acc_exp, 1'b0, 1'b0, 1'b0, 1'b0);
    chk({neg_out, zero_out}, flg);
    nx_carry = 1'b1;
    old      = u_mem.mem[12'h744];
    foreach (offs[i]) begin
      n = offs[i];
      run({OPC_BR_CARRY, n}, {OPC_CLR_BIT, 3'd1, 1'b1, 8'h44}, 1'b1);
      outs(acc_exp, 1'b0, 1'b0, 1'b1, 1'b1);
      chk(pc_value_out, PC_W'(nx_pc + {{12{n[7]}}, n, 1'b0}));
      chk({neg_out, zero_out}, flg);
    end
    $display("test branch finished");
    nx_carry = 1'b0;
    old2     = u_mem.mem[12'h745];
    f        = u_mem.mem[12'h746];
    run({OPC_CLR_BIT, 3'd2, 1'b1, 8'h45}, {OPC_CLR_BIT, 3'd4, 1'b1, 8'h46}, 1'b1);
    outs(acc_exp, 1'b1, 1'b0, 1'b0, 1'b0);
    run({OPC_AND_IMM, 8'hff}, 16'h0000, 1'b0);
    chk(u_mem.mem[12'h744], old);
    chk(u_mem.mem[12'h745], old2 & 8'hfb);
    chk(u_mem.mem[12'h746], f & 8'hef);
    $display("test back to back finished");
    conclude();
  end
endmodule : and_branch_bitclear_exec_bench

`default_nettype wire
